/* core/gpio_port_c_pkg.sv */
// package: register map, field layout, reset values and timing constants for the port
// assumes: AXI4-Lite slave with 32-bit data, one register per aligned word
package gpio_port_c_pkg;

    // ************************************************************
    // register indices and address width
    // ************************************************************
    localparam logic [7:0] IDX_MODE_LOW    = 8'h33;
    localparam logic [7:0] IDX_MODE_HIGH   = 8'h34;
    localparam logic [7:0] IDX_DIRECTION   = 8'h35;
    localparam logic [7:0] IDX_INT_ENABLE  = 8'h36;
    localparam logic [7:0] IDX_SAMPLE_SEL  = 8'h37;
    localparam logic [7:0] IDX_ALT_FUNC    = 8'h38;
    localparam logic [7:0] IDX_OUT_LATCH   = 8'h39;
    localparam logic [7:0] IDX_SERIAL_CTRL = 8'h3A;
    localparam logic [7:0] IDX_INT_STATUS  = 8'h3B;

    localparam int         ADDR_WIDTH = 12;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [3:0] RST_MODE_LOW   = 4'h0;
    localparam logic [3:0] RST_MODE_HIGH  = 4'h0;
    localparam logic [3:0] RST_DIRECTION  = 4'h0;
    localparam logic [3:0] RST_INT_ENABLE = 4'h0;
    localparam logic [3:0] RST_SAMPLE_SEL = 4'h0;
    localparam logic [3:0] RST_ALT_FUNC   = 4'h0;
    localparam logic [3:0] RST_OUT_LATCH  = 4'h0;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int         SAMPLING_RATE_BIT  = 0;
    localparam int         PIN0_FUNCTION_BIT  = 0;
    localparam int         PIN1_FUNCTION_BIT  = 1;
    localparam int         PIN2_FUNCTION_BIT  = 2;
    localparam int         PIN3_FUNCTION_BIT  = 3;
    localparam int         TX_CLK_SOURCE_BIT  = 0;
    localparam int         RX_CLK_SOURCE_BIT  = 1;
    localparam int         MODE_HIZ_BIT       = 0;
    localparam int         MODE_PULL_UP_BIT   = 1;

    // output mode encodings
    localparam logic [1:0] OUT_CMOS  = 2'h0;
    localparam logic [1:0] OUT_NOD   = 2'h1;
    localparam logic [1:0] OUT_POD   = 2'h2;
    localparam logic [1:0] OUT_HIZ   = 2'h3;

    localparam logic [15:0] INT_VECTOR = 16'h0016;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int         CLK_HZ        = 10000000;
    localparam int         SLOW_RATE_HZ  = 128;
    localparam int         FAST_RATE_HZ  = 4000;
    localparam int         SLOW_CYCLES   = CLK_HZ / SLOW_RATE_HZ;
    localparam int         FAST_CYCLES   = CLK_HZ / FAST_RATE_HZ;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* core/gpio_port_c.sv */
// four-bit general-purpose port with serial-port pin sharing and level-change interrupt
// assumes: one 10 MHz clock, synchronous reset, AXI4-Lite master on the register side,
// pad cells that apply pull and drive from the per-pin control outputs
`timescale 1ns/1ps

module gpio_port_c #(
    parameter int SLOW_CYCLES = gpio_port_c_pkg::SLOW_CYCLES,
    parameter int FAST_CYCLES = gpio_port_c_pkg::FAST_CYCLES
) (
    input  wire logic                                 CLK,
    input  wire logic                                 SRST,
    input  wire logic [gpio_port_c_pkg::ADDR_WIDTH-1:0] S_AXI_AWADDR,
    input  wire logic                                 S_AXI_AWVALID,
    output logic                                      S_AXI_AWREADY,
    input  wire logic [31:0]                          S_AXI_WDATA,
    input  wire logic [3:0]                           S_AXI_WSTRB,
    input  wire logic                                 S_AXI_WVALID,
    output logic                                      S_AXI_WREADY,
    output logic [1:0]                                S_AXI_BRESP,
    output logic                                      S_AXI_BVALID,
    input  wire logic                                 S_AXI_BREADY,
    input  wire logic [gpio_port_c_pkg::ADDR_WIDTH-1:0] S_AXI_ARADDR,
    input  wire logic                                 S_AXI_ARVALID,
    output logic                                      S_AXI_ARREADY,
    output logic [31:0]                               S_AXI_RDATA,
    output logic [1:0]                                S_AXI_RRESP,
    output logic                                      S_AXI_RVALID,
    input  wire logic                                 S_AXI_RREADY,
    input  wire logic [3:0]                           PIN_IN,
    output logic [3:0]                                PIN_OUT,
    output logic [3:0]                                PIN_OE,
    output logic [3:0]                                PULL_UP_EN,
    output logic [3:0]                                PULL_DOWN_EN,
    input  wire logic                                 SERIAL_TX_DATA,
    input  wire logic                                 SERIAL_TX_CLOCK_OUT,
    input  wire logic                                 SERIAL_RX_CLOCK_OUT,
    output logic                                      SERIAL_RX_DATA,
    output logic                                      SERIAL_TX_CLOCK_IN,
    output logic                                      SERIAL_RX_CLOCK_IN,
    output logic                                      EXTERNAL_INTERRUPT_REQUEST,
    output logic [15:0]                               INTERRUPT_VECTOR
);

    // ************************************************************
    // registers
    // ************************************************************
    logic [3:0]  mode_low_q;
    logic [3:0]  mode_high_q;
    logic [3:0]  direction_q;
    logic [3:0]  int_enable_q;
    logic [3:0]  sample_sel_q;
    logic [3:0]  alt_func_q;
    logic [3:0]  out_latch_q;
    logic [1:0]  serial_ctrl_q;
    logic        int_flag_q;

    logic [3:0]  sync1_q;
    logic [3:0]  sync2_q;
    logic [3:0]  sampled_q;
    logic [31:0] div_q;
    logic        sample_clk_q;
    logic        sample_clk_prev_q;

    logic        aw_held_q;
    logic        w_held_q;
    logic [gpio_port_c_pkg::ADDR_WIDTH-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;

    logic [3:0]  eff_dir;
    logic [3:0]  data_read;
    logic        wr_fire;
    logic [7:0]  wr_idx;
    logic        wr_hit;
    logic [7:0]  rd_idx;
    logic [3:0]  rd_val;
    logic        rd_hit;
    logic        sample_fall;
    logic        level_change;
    logic        flag_clear;

    // ************************************************************
    // pin direction and drive
    // ************************************************************
    logic [1:0] pin_mode [4];
    always_comb begin
        pin_mode[0] = mode_low_q[1:0];
        pin_mode[1] = mode_low_q[3:2];
        pin_mode[2] = mode_high_q[1:0];
        pin_mode[3] = mode_high_q[3:2];
        eff_dir = direction_q;
        if (alt_func_q[gpio_port_c_pkg::PIN0_FUNCTION_BIT]) begin
            eff_dir[0] = 1'b0;
        end
        if (alt_func_q[gpio_port_c_pkg::PIN1_FUNCTION_BIT]) begin
            eff_dir[1] = serial_ctrl_q[gpio_port_c_pkg::TX_CLK_SOURCE_BIT];
        end
        if (alt_func_q[gpio_port_c_pkg::PIN2_FUNCTION_BIT]) begin
            eff_dir[2] = serial_ctrl_q[gpio_port_c_pkg::RX_CLK_SOURCE_BIT];
        end
        if (alt_func_q[gpio_port_c_pkg::PIN3_FUNCTION_BIT]) begin
            eff_dir[3] = 1'b1;
        end
    end

    logic [3:0] drive_val;
    always_comb begin
        drive_val = out_latch_q;
        if (alt_func_q[gpio_port_c_pkg::PIN1_FUNCTION_BIT]) begin
            drive_val[1] = SERIAL_TX_CLOCK_OUT;
        end
        if (alt_func_q[gpio_port_c_pkg::PIN2_FUNCTION_BIT]) begin
            drive_val[2] = SERIAL_RX_CLOCK_OUT;
        end
        if (alt_func_q[gpio_port_c_pkg::PIN3_FUNCTION_BIT]) begin
            drive_val[3] = SERIAL_TX_DATA;
        end
    end

    // pad controls registered so outputs come from flip-flops
    always_ff @(posedge CLK) begin
        if (SRST) begin
            PIN_OUT      <= 4'h0;
            PIN_OE       <= 4'h0;
            PULL_UP_EN   <= 4'h0;
            PULL_DOWN_EN <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                PIN_OUT[i]      <= drive_val[i];
                PIN_OE[i]       <= 1'b0;
                PULL_UP_EN[i]   <= 1'b0;
                PULL_DOWN_EN[i] <= 1'b0;
                if (eff_dir[i]) begin
                    case (pin_mode[i])
                        gpio_port_c_pkg::OUT_CMOS: PIN_OE[i] <= 1'b1;
                        gpio_port_c_pkg::OUT_NOD:  PIN_OE[i] <= ~drive_val[i];
                        gpio_port_c_pkg::OUT_POD:  PIN_OE[i] <= drive_val[i];
                        default:                   PIN_OE[i] <= 1'b0;
                    endcase
                end else if (!pin_mode[i][gpio_port_c_pkg::MODE_HIZ_BIT]) begin
                    PULL_UP_EN[i]   <= pin_mode[i][gpio_port_c_pkg::MODE_PULL_UP_BIT];
                    PULL_DOWN_EN[i] <= ~pin_mode[i][gpio_port_c_pkg::MODE_PULL_UP_BIT];
                end
            end
        end
    end

    // ************************************************************
    // input synchroniser and serial inputs
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (SRST) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= PIN_IN;
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            SERIAL_RX_DATA     <= 1'b0;
            SERIAL_TX_CLOCK_IN <= 1'b0;
            SERIAL_RX_CLOCK_IN <= 1'b0;
        end else begin
            SERIAL_RX_DATA     <= alt_func_q[gpio_port_c_pkg::PIN0_FUNCTION_BIT]
                                & sync2_q[0];
            SERIAL_TX_CLOCK_IN <= alt_func_q[gpio_port_c_pkg::PIN1_FUNCTION_BIT] & sync2_q[1];
            SERIAL_RX_CLOCK_IN <= alt_func_q[gpio_port_c_pkg::PIN2_FUNCTION_BIT] & sync2_q[2];
        end
    end

    // constant vector, held in a flop so the output comes from a register
    always_ff @(posedge CLK) begin
        if (SRST) begin
            INTERRUPT_VECTOR <= 16'h0000;
        end else begin
            INTERRUPT_VECTOR <= gpio_port_c_pkg::INT_VECTOR;
        end
    end

    // ************************************************************
    // sampling clock and level-change interrupt
    // ************************************************************
    logic [31:0] half_period;
    assign half_period = sample_sel_q[gpio_port_c_pkg::SAMPLING_RATE_BIT] ?
                         32'(FAST_CYCLES / 2) : 32'(SLOW_CYCLES / 2);

    always_ff @(posedge CLK) begin
        if (SRST) begin
            div_q             <= 32'h0;
            sample_clk_q      <= 1'b0;
            sample_clk_prev_q <= 1'b0;
        end else begin
            sample_clk_prev_q <= sample_clk_q;
            if (div_q + 32'h1 >= half_period) begin
                div_q        <= 32'h0;
                sample_clk_q <= ~sample_clk_q;
            end else begin
                div_q <= div_q + 32'h1;
            end
        end
    end

    assign sample_fall  = sample_clk_prev_q & ~sample_clk_q;
    assign level_change = |((sync2_q ^ sampled_q) & int_enable_q);

    always_ff @(posedge CLK) begin
        if (SRST) begin
            sampled_q <= 4'h0;
        end else if (sample_fall) begin
            sampled_q <= sync2_q;
        end
    end

    // flag cleared by writing 1 to bit 0 of status; set wins
    always_ff @(posedge CLK) begin
        if (SRST) begin
            int_flag_q                 <= 1'b0;
            EXTERNAL_INTERRUPT_REQUEST <= 1'b0;
        end else begin
            EXTERNAL_INTERRUPT_REQUEST <= sample_fall & level_change;
            if (sample_fall & level_change) begin
                int_flag_q <= 1'b1;
            end else if (flag_clear) begin
                int_flag_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // AXI4-Lite write path
    // ************************************************************
    assign wr_fire = aw_held_q & w_held_q & ~S_AXI_BVALID;
    assign wr_idx  = aw_addr_q[9:2];
    assign wr_hit  = wr_fire & w_strb_q[0];

    always_ff @(posedge CLK) begin
        if (SRST) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            aw_addr_q     <= '0;
            w_data_q      <= 32'h0;
            w_strb_q      <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= gpio_port_c_pkg::RESP_OKAY;
        end else begin
            S_AXI_AWREADY <= ~aw_held_q & ~S_AXI_AWREADY & ~S_AXI_BVALID;
            S_AXI_WREADY  <= ~w_held_q & ~S_AXI_WREADY & ~S_AXI_BVALID;
            if (S_AXI_AWVALID & S_AXI_AWREADY) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID & S_AXI_WREADY) begin
                w_held_q <= 1'b1;
                w_data_q <= S_AXI_WDATA;
                w_strb_q <= S_AXI_WSTRB;
                S_AXI_WREADY <= 1'b0;
            end
            if (wr_fire) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= (wr_idx >= gpio_port_c_pkg::IDX_MODE_LOW &&
                                 wr_idx <= gpio_port_c_pkg::IDX_INT_STATUS) ?
                                gpio_port_c_pkg::RESP_OKAY : gpio_port_c_pkg::RESP_SLVERR;
            end else if (S_AXI_BVALID & S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    assign flag_clear = wr_hit & (wr_idx == gpio_port_c_pkg::IDX_INT_STATUS) & w_data_q[0];

    always_ff @(posedge CLK) begin
        if (SRST) begin
            mode_low_q    <= gpio_port_c_pkg::RST_MODE_LOW;
            mode_high_q   <= gpio_port_c_pkg::RST_MODE_HIGH;
            direction_q   <= gpio_port_c_pkg::RST_DIRECTION;
            int_enable_q  <= gpio_port_c_pkg::RST_INT_ENABLE;
            sample_sel_q  <= gpio_port_c_pkg::RST_SAMPLE_SEL;
            alt_func_q    <= gpio_port_c_pkg::RST_ALT_FUNC;
            out_latch_q   <= gpio_port_c_pkg::RST_OUT_LATCH;
            serial_ctrl_q <= 2'h0;
        end else if (wr_hit) begin
            case (wr_idx)
                gpio_port_c_pkg::IDX_MODE_LOW:    mode_low_q    <= w_data_q[3:0];
                gpio_port_c_pkg::IDX_MODE_HIGH:   mode_high_q   <= w_data_q[3:0];
                gpio_port_c_pkg::IDX_DIRECTION:   direction_q   <= w_data_q[3:0];
                gpio_port_c_pkg::IDX_INT_ENABLE:  int_enable_q  <= w_data_q[3:0];
                gpio_port_c_pkg::IDX_SAMPLE_SEL:  sample_sel_q  <= {3'h0, w_data_q[0]};
                gpio_port_c_pkg::IDX_ALT_FUNC:    alt_func_q    <= w_data_q[3:0];
                gpio_port_c_pkg::IDX_OUT_LATCH:   out_latch_q   <= w_data_q[3:0];
                gpio_port_c_pkg::IDX_SERIAL_CTRL: serial_ctrl_q <= w_data_q[1:0];
                default: ;
            endcase
        end
    end

    // ************************************************************
    // AXI4-Lite read path
    // ************************************************************
    assign data_read = (out_latch_q & eff_dir) | (sync2_q & ~eff_dir);
    assign rd_idx    = S_AXI_ARADDR[9:2];

    always_comb begin
        rd_hit = 1'b1;
        case (rd_idx)
            gpio_port_c_pkg::IDX_MODE_LOW:    rd_val = mode_low_q;
            gpio_port_c_pkg::IDX_MODE_HIGH:   rd_val = mode_high_q;
            gpio_port_c_pkg::IDX_DIRECTION:   rd_val = direction_q;
            gpio_port_c_pkg::IDX_INT_ENABLE:  rd_val = int_enable_q;
            gpio_port_c_pkg::IDX_SAMPLE_SEL:  rd_val = sample_sel_q;
            gpio_port_c_pkg::IDX_ALT_FUNC:    rd_val = alt_func_q;
            gpio_port_c_pkg::IDX_OUT_LATCH:   rd_val = data_read;
            gpio_port_c_pkg::IDX_SERIAL_CTRL: rd_val = {2'h0, serial_ctrl_q};
            gpio_port_c_pkg::IDX_INT_STATUS:  rd_val = {3'h0, int_flag_q};
            default: begin
                rd_val = 4'h0;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0;
            S_AXI_RRESP   <= gpio_port_c_pkg::RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= ~S_AXI_ARREADY & ~S_AXI_RVALID & S_AXI_ARVALID;
            if (S_AXI_ARVALID & S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA  <= {28'h0, rd_val};
                S_AXI_RRESP  <= rd_hit ? gpio_port_c_pkg::RESP_OKAY
                                       : gpio_port_c_pkg::RESP_SLVERR;
            end else if (S_AXI_RVALID & S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

endmodule

/* test/gpio_port_c_monitor.sv */
// checker: bus and pin relations seen at the port block's top ports
// assumes: bound to gpio_port_c, one clock, synchronous reset high
`timescale 1ns/1ps
module gpio_port_c_monitor (
    input wire logic        CLK,
    input wire logic        SRST,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WREADY,
    input wire logic        S_AXI_BVALID,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic        S_AXI_ARREADY,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [3:0]  PIN_OE,
    input wire logic [3:0]  PULL_UP_EN,
    input wire logic [3:0]  PULL_DOWN_EN,
    input wire logic        EXTERNAL_INTERRUPT_REQUEST,
    input wire logic [15:0] INTERRUPT_VECTOR
);
    default clocking dc @(posedge CLK); endclocking
    default disable iff (SRST);
    property p_vec; !$past(SRST) |-> INTERRUPT_VECTOR == 16'h0016; endproperty
    a_vec: assert property (p_vec) else $error("vector wrong");
    property p_rst; $fell(SRST) |-> PIN_OE == 4'h0 && PULL_UP_EN == 4'h0; endproperty
    a_rst: assert property (p_rst) else $error("pins not idle after reset");
    property p_pull;
        (PULL_UP_EN & PULL_DOWN_EN) == 4'h0 && ((PULL_UP_EN | PULL_DOWN_EN) & PIN_OE) == 4'h0;
    endproperty
    a_pull: assert property (p_pull) else $error("pull clash");
    property p_bpair; $rose(S_AXI_BVALID) |-> $past(S_AXI_AWREADY, 2) || $past(S_AXI_WREADY, 2);
    endproperty
    a_bpair: assert property (p_bpair) else $error("write answer unprompted");
    property p_rpair; $rose(S_AXI_RVALID) |-> $past(S_AXI_ARREADY); endproperty
    a_rpair: assert property (p_rpair) else $error("read answer unprompted");
    property p_rdone; S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID; endproperty
    a_rdone: assert property (p_rdone) else $error("read answer repeated");
    property p_rhi; S_AXI_RVALID |-> S_AXI_RDATA[31:4] == 28'h0; endproperty
    a_rhi: assert property (p_rhi) else $error("upper read bits set");
    property p_irq; EXTERNAL_INTERRUPT_REQUEST |=> !EXTERNAL_INTERRUPT_REQUEST [*4]; endproperty
    a_irq: assert property (p_irq) else $error("request too frequent");
    property p_ardy; S_AXI_ARREADY |=> !S_AXI_ARREADY; endproperty
    a_ardy: assert property (p_ardy) else $error("read ready held");
    c_irq: cover property (EXTERNAL_INTERRUPT_REQUEST);
    c_err: cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h2);
    c_rd: cover property ($rose(S_AXI_RVALID));
endmodule
bind gpio_port_c gpio_port_c_monitor u_gpio_port_c_monitor (.*);

/* test/gpio_port_c_pins.sv */
// pin model: pads with pulls, outside drivers and the serial port's outputs
// assumes: PIN_OUT, PIN_OE and the pull enables come from the port block; ext_* and adv from the bench
`timescale 1ns/1ps
module gpio_port_c_pins (
    input  wire logic       CLK,
    input  wire logic [3:0] PIN_OUT,
    input  wire logic [3:0] PIN_OE,
    input  wire logic [3:0] PULL_UP_EN,
    input  wire logic [3:0] PULL_DOWN_EN,
    input  wire logic [3:0] ext_val,
    input  wire logic [3:0] ext_en,
    input  wire logic       adv,
    output logic      [3:0] PIN_IN,
    output logic            SERIAL_TX_DATA,
    output logic            SERIAL_TX_CLOCK_OUT,
    output logic            SERIAL_RX_CLOCK_OUT
);
    logic [3:0] last_q = 4'h0;
    logic [2:0] ser_q  = 3'h0;
    // pad drive wins, then outside driver, then pulls; a floating pad flips each cycle
    assign PIN_IN = (PIN_OE & PIN_OUT) | (~PIN_OE & ext_en & ext_val)
                  | (~PIN_OE & ~ext_en & (PULL_UP_EN | (~PULL_DOWN_EN & ~last_q)));
    always_ff @(posedge CLK) begin
        last_q <= PIN_IN;
        if (adv) ser_q <= ser_q + 3'h1;
    end
    assign SERIAL_TX_DATA      = ser_q[0];
    assign SERIAL_TX_CLOCK_OUT = ser_q[1];
    assign SERIAL_RX_CLOCK_OUT = ser_q[2];
endmodule

/* test/gpio_port_c_tb_top.sv */
// testbench: registers, pin modes, shared functions and interrupt of the port
// assumes: pin model alongside; sample periods shortened to 8 and 16 clocks
`timescale 1ns/1ps
module gpio_port_c_tb_top;
    localparam int FAST = 8;
    localparam int SLOW = 16;
    logic        CLK = 1'b0, SRST = 1'b1, adv = 1'b0, S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0;
    logic        S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
    logic [11:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
    logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA;
    logic [3:0]  S_AXI_WSTRB = 4'hF, ext_val = '0, ext_en = '0, PIN_IN, PIN_OUT, PIN_OE;
    logic [3:0]  PULL_UP_EN, PULL_DOWN_EN;
    logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
    logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic        SERIAL_TX_DATA, SERIAL_TX_CLOCK_OUT, SERIAL_RX_CLOCK_OUT, SERIAL_RX_DATA;
    logic        SERIAL_TX_CLOCK_IN, SERIAL_RX_CLOCK_IN, EXTERNAL_INTERRUPT_REQUEST;
    logic [15:0] INTERRUPT_VECTOR;
    int          mismatches = 0, n_compared = 0, cyc = 0, irqs = 0;
    logic [33:0] qr[$];
    logic [1:0]  qb[$];
    gpio_port_c #(.SLOW_CYCLES(SLOW), .FAST_CYCLES(FAST)) u_gpio_port_c (.*);
    gpio_port_c_pins u_gpio_port_c_pins (.*);
    always #50 CLK = ~CLK;
    task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    function automatic logic [1:0] rsp(input logic [7:0] i);
        return (i >= 8'h33 && i <= 8'h3B) ? 2'h0 : 2'h2;
    endfunction
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        logic a, w;
        qb.push_back(rsp(i));
        @(posedge CLK);
        S_AXI_AWADDR <= {2'b00, i, 2'b00};
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        a = 1'b0;
        w = 1'b0;
        while (!(a && w)) begin
            @(posedge CLK);
            a |= S_AXI_AWREADY;
            w |= S_AXI_WREADY;
            if (a) S_AXI_AWVALID <= 1'b0;
            if (w) S_AXI_WVALID <= 1'b0;
        end
        do @(posedge CLK); while (!S_AXI_BVALID);
        S_AXI_BREADY <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] i, input logic [3:0] d);
        qr.push_back({rsp(i), 28'h0, d});
        @(posedge CLK);
        S_AXI_ARADDR <= {2'b00, i, 2'b00};
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        do @(posedge CLK); while (!S_AXI_ARREADY);
        S_AXI_ARVALID <= 1'b0;
        do @(posedge CLK); while (!S_AXI_RVALID);
        S_AXI_RREADY <= 1'b0;
    endtask
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        irqs <= irqs + int'(EXTERNAL_INTERRUPT_REQUEST === 1'b1);
        if (S_AXI_RVALID && S_AXI_RREADY) chk("rd", qr.pop_front(), {S_AXI_RRESP, S_AXI_RDATA});
        if (S_AXI_BVALID && S_AXI_BREADY) chk("wr", qb.pop_front(), S_AXI_BRESP);
        if (cyc == 20000) begin
            mismatches++;
            end_sim;
        end
    end
    initial begin
        logic [3:0] d, e, oe, pu, pd;
        int k, n;
        void'($urandom(56785));
        repeat (5) @(posedge CLK);
        SRST <= 1'b0;
        for (int i = 8'h33; i <= 8'h3B; i++) rd(8'(i), 4'h0);
        rd(8'h40, 4'h0);
        wr(8'h40, '0);
        for (int i = 8'h33; i <= 8'h38; i++) begin
            d = 4'($urandom);
            wr(8'(i), {28'($urandom), d});
            rd(8'(i), i == 8'h37 ? {3'h0, d[0]} : d);
        end
        SRST <= 1'b1;
        repeat (2) @(posedge CLK);
        SRST <= 1'b0;
        S_AXI_WSTRB <= 4'hE;
        wr(8'h35, 32'hF);
        S_AXI_WSTRB <= 4'hF;
        rd(8'h35, 4'h0);
        $display("register test done");
        d = 4'($urandom);
        wr(8'h39, d);
        wr(8'h35, 32'hF);
        repeat (2) @(posedge CLK);
        chk("out", d, PIN_OUT);
        rd(8'h39, d);
        e = 4'($urandom);
        ext_en <= 4'hA;
        ext_val <= e;
        wr(8'h35, 32'h5);
        repeat (3) @(posedge CLK);
        rd(8'h39, (d & 4'h5) | (e & 4'hA));
        ext_en <= 4'h0;
        for (int m = 0; m < 4; m++) begin
            wr(8'h33, {28'h0, 2'(m + 1), 2'(m)});
            wr(8'h34, {28'h0, 2'(m + 3), 2'(m + 2)});
            for (int o = 0; o < 2; o++) begin
                wr(8'h35, o ? 32'hF : 32'h0);
                repeat (2) @(posedge CLK);
                for (int p = 0; p < 4; p++) begin
                    k = (m + p) % 4;
                    oe[p] = o && (k == 0 || (k == 1 && !d[p]) || (k == 2 && d[p]));
                    pu[p] = !o && k == 2;
                    pd[p] = !o && k == 0;
                end
                chk("oe", oe, PIN_OE);
                chk("pu", pu, PULL_UP_EN);
                chk("pd", pd, PULL_DOWN_EN);
                chk("out", d & oe, PIN_OUT & oe);
            end
        end
        $display("mode test done");
        wr(8'h33, '0);
        wr(8'h34, '0);
        wr(8'h38, 32'hF);
        ext_en <= 4'h7;
        for (int c = 1; c < 3; c++) begin
            wr(8'h3A, c);
            for (int j = 0; j < 2; j++) begin
                e = 4'($urandom);
                ext_val <= e;
                adv <= 1'b1;
                @(posedge CLK);
                adv <= 1'b0;
                repeat (4) @(posedge CLK);
                chk("oe", {1'b1, c == 2, c == 1, 1'b0}, PIN_OE);
                chk("txd", SERIAL_TX_DATA, PIN_OUT[3]);
                chk("rxd", e[0], SERIAL_RX_DATA);
                chk("clk", c == 1 ? e[2] : e[1],
                    c == 1 ? SERIAL_RX_CLOCK_IN : SERIAL_TX_CLOCK_IN);
                chk("clko", c == 1 ? SERIAL_TX_CLOCK_OUT : SERIAL_RX_CLOCK_OUT,
                    c == 1 ? PIN_OUT[1] : PIN_OUT[2]);
            end
        end
        $display("function test done");
        wr(8'h38, '0);
        wr(8'h3A, '0);
        ext_en <= 4'hF;
        ext_val <= 4'h0;
        wr(8'h35, '0);
        wr(8'h36, 32'h1);
        for (int s = 1; s >= 0; s--) begin
            n = s ? FAST : SLOW;
            wr(8'h37, s);
            repeat (2 * n) @(posedge CLK);
            wr(8'h3B, 32'h1);
            k = irqs;
            ext_val[1] <= ~ext_val[1];
            repeat (2 * n) @(posedge CLK);
            chk("irq", k, irqs);
            ext_val[0] <= ~ext_val[0];
            repeat (n + 6) @(posedge CLK);
            chk("irq", k + 1, irqs);
            rd(8'h3B, 4'h1);
            wr(8'h3B, 32'h1);
            rd(8'h3B, 4'h0);
        end
        $display("interrupt test done");
        end_sim;
    end
endmodule
